// *** src/ddr_cmd_pkg.sv ***
// shared constants, command set and decode for the ddr module link
// assumes one 50 MHz reference clock; one tCK is two reference clocks
package ddr_cmd_pkg;
   // link geometry
   localparam int DQ_W       = 16;
   localparam int DM_W       = DQ_W / 8;
   localparam int ROW_W      = 13;
   localparam int COL_W      = 4;               // column address bits modelled per bank
   localparam int AP_BIT     = 10;              // precharge select line
   localparam int HALF_PER_CK = 2;              // reference clocks per tCK
   // mode register fields
   localparam int MR_BL_LSB  = 0;
   localparam int MR_CL_LSB  = 4;
   localparam logic [2:0] MR_BL2  = 3'h1;
   localparam logic [2:0] MR_BL4  = 3'h2;
   localparam logic [2:0] MR_BL8  = 3'h3;
   localparam logic [2:0] MR_CL25 = 3'h6;
   localparam logic [3:0] BL_RESET = 4'h4;      // burst beats after reset
   // latencies: read and stop delays in reference clocks, write data and mask in tCK
   localparam logic [2:0] CL2_HALF   = 3'h4;    // read latency 2
   localparam logic [2:0] CL25_HALF  = 3'h5;    // read latency 2.5
   localparam logic [2:0] STOP2_HALF = 3'h4;    // stop_to_float_delay cl 2
   localparam logic [2:0] STOP25_HALF = 3'h5;   // stop_to_float_delay cl 2.5
   localparam logic [1:0] WRITE_DATA_LATENCY = 2'h1; // tCK
   localparam logic [1:0] MASK_LATENCY       = 2'h0; // tCK
   // command gaps in tCK
   localparam logic [8:0] WR_PRE_FAST   = 9'h004;
   localparam logic [8:0] WR_PRE_SLOW   = 9'h003;
   localparam logic [8:0] WR_RD_BASE    = 9'h002;
   localparam logic [8:0] STOP_WR_CL2   = 9'h002;
   localparam logic [8:0] STOP_WR_CL25  = 9'h003;
   localparam logic [8:0] RD_WR_CL2     = 9'h002;
   localparam logic [8:0] RD_WR_CL25    = 9'h003;
   localparam logic [8:0] MODE_SET_GAP  = 9'h002;
   localparam logic [8:0] SR_NONRD_FAST = 9'h00C;
   localparam logic [8:0] SR_NONRD_SLOW = 9'h00A;
   localparam logic [8:0] SR_RD_GAP     = 9'h0C8;
   localparam logic [8:0] PD_EXIT_GAP   = 9'h001;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_BST, CMD_MRS,
      CMD_PD_ENTER, CMD_SR_ENTER, CMD_EXIT
   } cmd_t;

   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOWN, PWR_SELF} pwr_t;

   // row, column and write strobe levels to command
   function automatic cmd_t decode_cmd(input logic ras_n, input logic cas_n,
                                       input logic we_n);
      case ({ras_n, cas_n, we_n})
         3'b011:  decode_cmd = CMD_ACT;
         3'b101:  decode_cmd = CMD_RD;
         3'b100:  decode_cmd = CMD_WR;
         3'b010:  decode_cmd = CMD_PRE;
         3'b001:  decode_cmd = CMD_REF;
         3'b110:  decode_cmd = CMD_BST;
         3'b000:  decode_cmd = CMD_MRS;
         default: decode_cmd = CMD_NOP;
      endcase
   endfunction

   // mode register burst code to beats
   function automatic logic [3:0] bl_beats(input logic [2:0] code);
      case (code)
         MR_BL2:  bl_beats = 4'h2;
         MR_BL8:  bl_beats = 4'h8;
         default: bl_beats = 4'h4;
      endcase
   endfunction
endpackage

// *** src/ddr_link_if.sv ***
// command, strobe and data wires between controller and module
// assumes both ends share i_ref_clk; each end drives its own copy of dq/dqs
`timescale 1ns/1ps
interface ddr_link_if;
   import ddr_cmd_pkg::*;
   logic              cmd_tick;   // command edge, once per tCK
   logic              cke;
   logic              cs_n;
   logic              ras_n;
   logic              cas_n;
   logic              we_n;
   logic [1:0]        ba;
   logic [ROW_W-1:0]  addr;
   logic [DQ_W-1:0]   dq_h;
   logic              dq_h_oe;
   logic [DQ_W-1:0]   dq_d;
   logic              dq_d_oe;
   logic              dqs_h;
   logic              dqs_h_oe;
   logic              dqs_d;
   logic              dqs_d_oe;
   logic [DM_W-1:0]   dm;

   modport host (output cmd_tick, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                 dq_h, dq_h_oe, dqs_h, dqs_h_oe, dm,
                 input dq_d, dq_d_oe, dqs_d, dqs_d_oe);
   modport device (input cmd_tick, cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                   dq_h, dq_h_oe, dqs_h, dqs_h_oe, dm,
                   output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
endinterface

// *** src/ddr_gap_timer.sv ***
// down counter that holds off a command until its gap has passed
// assumes load value is already in reference clocks
`timescale 1ns/1ps
module ddr_gap_timer #(
   parameter int W = 9
) (
   // clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_resetn,
   // control
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_value,
   output logic              o_done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // reload or count toward zero
   always_comb begin
      cnt_d = cnt_q;
      if (i_load) begin
         cnt_d = i_value;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_done = (cnt_q == '0);
endmodule

// *** src/ddr_module_end.sv ***
// module end of the ddr link: decode, bank state, read and write bursts
// assumes the controller keeps every command gap; one tCK is two clocks
// Function
// - controller waits write-to-precharge gap per grade
// - controller waits half burst read-to-precharge
// - controller waits write-to-read gap
// - controller waits stop-to-write gap by latency
// - data floats exactly latency after burst stop
// - controller waits read-to-write gap by latency
// - data floats exactly latency after precharge of the read bank or all banks
// - first write beat one tCK after command
// - mask applies to same write beat
// - controller waits two cycles after mode set
// - controller waits after self refresh exit
// - power-down entry and exit each hold off the next command two tCK
// - commands taken only with chip select low
// - activate captures row from address lines
// - read/write take column as burst start
// - precharge all or selected bank by select
// - select line enables auto precharge on bursts
// - bank number is two select bits
// - clock enable low enters, high exits power
// - controller holds clock enable a full cycle
// - module drives strobe on reads, samples on writes
`timescale 1ns/1ps
module ddr_module_end
   import ddr_cmd_pkg::*;
(
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // link
   ddr_link_if.device       link,
   // status
   output logic [3:0]       o_bank_open,
   output logic [1:0]       o_pwr_state,
   output logic             o_cl25,
   output logic [3:0]       o_burst_beats
);
   localparam int MEM_D = 4 * (1 << COL_W);

   logic [DQ_W-1:0]  mem [MEM_D];
   logic [3:0]       open_q, open_d;
   logic [ROW_W-1:0] row_q [4];
   logic [ROW_W-1:0] row_d [4];
   pwr_t             pwr_q, pwr_d;
   logic             cl25_q, cl25_d;
   logic [3:0]       bl_q, bl_d;
   // read engine
   logic [2:0]       rlat_q, rlat_d;
   logic [3:0]       rbeats_q, rbeats_d;
   logic [COL_W-1:0] rcol_q, rcol_d;
   logic [1:0]       rbank_q, rbank_d;
   logic             rap_q, rap_d;
   logic [2:0]       stop_q, stop_d;
   // write engine
   logic [1:0]       wlat_q, wlat_d;
   logic [3:0]       wbeats_q, wbeats_d;
   logic [COL_W-1:0] wcol_q, wcol_d;
   logic [1:0]       wbank_q, wbank_d;
   logic             wap_q, wap_d;
   // pins
   logic [DQ_W-1:0]  dq_q, dq_d;
   logic             oe_q, oe_d;
   logic             dqs_q, dqs_d;

   cmd_t             cmd;
   logic             take;
   logic [1:0]       bank;
   logic             wcap;

   // command decode, gated by tick and chip select
   always_comb begin
      bank = {link.ba[1], link.ba[0]};
      take = link.cmd_tick && !link.cs_n;
      cmd  = take ? decode_cmd(link.ras_n, link.cas_n, link.we_n) : CMD_NOP;
      wcap = (wlat_q == 2'h0) && (wbeats_q != 4'h0) && link.dqs_h_oe;
   end

   // next state of banks, mode, power and both burst engines
   always_comb begin
      open_d   = open_q;
      row_d    = row_q;
      pwr_d    = pwr_q;
      cl25_d   = cl25_q;
      bl_d     = bl_q;
      rlat_d   = rlat_q;
      rbeats_d = rbeats_q;
      rcol_d   = rcol_q;
      rbank_d  = rbank_q;
      rap_d    = rap_q;
      stop_d   = stop_q;
      wlat_d   = wlat_q;
      wbeats_d = wbeats_q;
      wcol_d   = wcol_q;
      wbank_d  = wbank_q;
      wap_d    = wap_q;
      // read burst: latency, then one beat per clock
      if (rlat_q != 3'h0) begin
         rlat_d = rlat_q - 3'h1;
      end else if (rbeats_q != 4'h0) begin
         rbeats_d = rbeats_q - 4'h1;
         rcol_d   = rcol_q + COL_W'(1);
         if (rbeats_q == 4'h1 && rap_q) begin
            open_d[rbank_q] = 1'b0;
         end
      end
      // truncation lands exactly one latency after stop or precharge
      if (stop_q != 3'h0) begin
         stop_d = stop_q - 3'h1;
         if (stop_q == 3'h1) begin
            rbeats_d = 4'h0;
            rlat_d   = 3'h0;
         end
      end
      // write burst: one tCK to first beat, then one beat per clock
      if (wlat_q != 2'h0) begin
         wlat_d = wlat_q - 2'h1;
      end else if (wcap) begin
         wbeats_d = wbeats_q - 4'h1;
         wcol_d   = wcol_q + COL_W'(1);
         if (wbeats_q == 4'h1 && wap_q) begin
            open_d[wbank_q] = 1'b0;
         end
      end
      // power state follows clock enable at the command edge
      if (link.cmd_tick) begin
         case (pwr_q)
            PWR_ACTIVE: begin
               if (!link.cke) begin
                  pwr_d = (cmd == CMD_REF) ? PWR_SELF : PWR_DOWN;
               end
            end
            PWR_DOWN, PWR_SELF: begin
               if (link.cke) begin
                  pwr_d = PWR_ACTIVE;
               end
            end
            default: pwr_d = PWR_ACTIVE;
         endcase
      end
      // command effects only while awake
      if (pwr_q == PWR_ACTIVE && link.cke) begin
         case (cmd)
            CMD_ACT: begin
               open_d[bank] = 1'b1;
               row_d[bank]  = link.addr;
            end
            CMD_RD: begin
               rlat_d   = cl25_q ? CL25_HALF : CL2_HALF;
               rbeats_d = bl_q;
               rcol_d   = link.addr[COL_W-1:0];
               rbank_d  = bank;
               rap_d    = link.addr[AP_BIT];
               stop_d   = 3'h0;
            end
            CMD_WR: begin
               wlat_d   = WRITE_DATA_LATENCY;
               wbeats_d = bl_q;
               wcol_d   = link.addr[COL_W-1:0];
               wbank_d  = bank;
               wap_d    = link.addr[AP_BIT];
            end
            CMD_PRE: begin
               if (link.addr[AP_BIT]) begin
                  open_d = 4'h0;
               end else begin
                  open_d[bank] = 1'b0;
               end
               if (link.addr[AP_BIT] || bank == rbank_q) begin
                  stop_d = cl25_q ? STOP25_HALF : STOP2_HALF;
               end
            end
            CMD_BST: begin
               stop_d = cl25_q ? STOP25_HALF : STOP2_HALF;
            end
            CMD_MRS: begin
               bl_d   = bl_beats(link.addr[MR_BL_LSB +: 3]);
               cl25_d = (link.addr[MR_CL_LSB +: 3] == MR_CL25);
            end
            default: ;
         endcase
      end
      // read drive and strobe from the next engine state
      oe_d  = (rlat_d == 3'h0) && (rbeats_d != 4'h0);
      dq_d  = mem[{rbank_d, rcol_d}];
      dqs_d = oe_d ? !dqs_q : 1'b0;
   end

   // captured write beat, each lane masked on its own beat
   always_ff @(posedge i_ref_clk) begin
      for (int b = 0; b < DM_W; b++) begin
         if (wcap && !link.dm[b]) begin
            mem[{wbank_q, wcol_q}][8*b +: 8] <= link.dq_h[8*b +: 8];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         open_q   <= 4'h0;
         row_q    <= '{default: '0};
         pwr_q    <= PWR_ACTIVE;
         cl25_q   <= 1'b0;
         bl_q     <= BL_RESET;
         rlat_q   <= 3'h0;
         rbeats_q <= 4'h0;
         rcol_q   <= '0;
         rbank_q  <= 2'h0;
         rap_q    <= 1'b0;
         stop_q   <= 3'h0;
         wlat_q   <= 2'h0;
         wbeats_q <= 4'h0;
         wcol_q   <= '0;
         wbank_q  <= 2'h0;
         wap_q    <= 1'b0;
         dq_q     <= '0;
         oe_q     <= 1'b0;
         dqs_q    <= 1'b0;
      end else begin
         open_q   <= open_d;
         row_q    <= row_d;
         pwr_q    <= pwr_d;
         cl25_q   <= cl25_d;
         bl_q     <= bl_d;
         rlat_q   <= rlat_d;
         rbeats_q <= rbeats_d;
         rcol_q   <= rcol_d;
         rbank_q  <= rbank_d;
         rap_q    <= rap_d;
         stop_q   <= stop_d;
         wlat_q   <= wlat_d;
         wbeats_q <= wbeats_d;
         wcol_q   <= wcol_d;
         wbank_q  <= wbank_d;
         wap_q    <= wap_d;
         dq_q     <= dq_d;
         oe_q     <= oe_d;
         dqs_q    <= dqs_d;
      end
   end

   // pins and status
   assign link.dq_d     = dq_q;
   assign link.dq_d_oe  = oe_q;
   assign link.dqs_d    = dqs_q;
   assign link.dqs_d_oe = oe_q;
   assign o_bank_open   = open_q;
   assign o_pwr_state   = pwr_q;
   assign o_cl25        = cl25_q;
   assign o_burst_beats = bl_q;
endmodule

// *** src/ddr_ctrl_end.sv ***
// controller end of the ddr link: command gaps, write drive, read capture
// assumes the user holds a request until ready; one tCK is two clocks
`timescale 1ns/1ps
module ddr_ctrl_end
   import ddr_cmd_pkg::*;
#(
   parameter bit FAST_GRADE = 1'b1   // 6 ns column when set, else 7.5 ns
) (
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_resetn,
   // user requests
   input  wire logic              i_req_valid,
   input  wire cmd_t              i_req_cmd,
   input  wire logic [1:0]        i_req_bank,
   input  wire logic [ROW_W-1:0]  i_req_addr,
   output logic                   o_req_ready,
   // write beats
   input  wire logic [DQ_W-1:0]   i_wdata,
   input  wire logic [DM_W-1:0]   i_wmask,
   output logic                   o_wbeat_take,
   // read beats
   output logic [DQ_W-1:0]        o_rdata,
   output logic                   o_rvalid,
   // link
   ddr_link_if.host               link
);
   localparam int NG = 7;
   typedef enum int {G_WR_PRE, G_RD_PRE, G_WR_RD, G_ST_WR, G_RD_WR, G_ANY, G_SR_RD} gap_t;

   logic             tick_q, tick_d;
   logic             cke_q, cke_d;
   logic             sr_q, sr_d;
   logic             cl25_q, cl25_d;
   logic [3:0]       bl_q, bl_d;
   logic [3:0]       pins_q, pins_d;      // cs_n ras_n cas_n we_n
   logic [1:0]       ba_q, ba_d;
   logic [ROW_W-1:0] addr_q, addr_d;
   logic [1:0]       wlat_q, wlat_d;
   logic [3:0]       wbeats_q, wbeats_d;
   logic [DQ_W-1:0]  dq_q, dq_d;
   logic [DM_W-1:0]  dm_q, dm_d;
   logic             oe_q, oe_d;
   logic             dqs_q, dqs_d;
   logic [DQ_W-1:0]  rd_q, rd_d;
   logic             rv_q, rv_d;
   logic             fire;
   logic [8:0]       half_bl;
   logic [NG-1:0]    load, done;
   logic [8:0]       gap_ck [NG];
   logic [8:0]       gap_val [NG];

   // one timer per gap kind, values in tCK turned into clocks
   for (genvar g = 0; g < NG; g++) begin : g_gap
      assign gap_val[g] = (gap_ck[g] == 9'h000) ? 9'h000
                          : 9'((gap_ck[g] << 1) - 9'h001);
      ddr_gap_timer #(.W(9)) u_gap (
         .i_ref_clk (i_ref_clk),
         .i_resetn  (i_resetn),
         .i_load    (load[g]),
         .i_value   (gap_val[g]),
         .o_done    (done[g])
      );
   end

   // readiness per command and which gaps each command starts
   always_comb begin
      half_bl = 9'(bl_q >> 1);
      gap_ck[G_WR_PRE] = (FAST_GRADE ? WR_PRE_FAST : WR_PRE_SLOW) + half_bl;
      gap_ck[G_RD_PRE] = half_bl;
      gap_ck[G_WR_RD]  = WR_RD_BASE + half_bl;
      gap_ck[G_ST_WR]  = cl25_q ? STOP_WR_CL25 : STOP_WR_CL2;
      gap_ck[G_RD_WR]  = (cl25_q ? RD_WR_CL25 : RD_WR_CL2) + half_bl;
      gap_ck[G_ANY]    = PD_EXIT_GAP;
      gap_ck[G_SR_RD]  = SR_RD_GAP;
      if (i_req_cmd == CMD_MRS) begin
         gap_ck[G_ANY] = MODE_SET_GAP;
      end else if (i_req_cmd == CMD_EXIT && sr_q) begin
         gap_ck[G_ANY] = FAST_GRADE ? SR_NONRD_FAST : SR_NONRD_SLOW;
      end else if (i_req_cmd inside {CMD_EXIT, CMD_PD_ENTER, CMD_SR_ENTER}) begin
         // clock enable level must still stand at the following command edge
         gap_ck[G_ANY] = PD_EXIT_GAP + 9'h001;
      end
      o_req_ready = !tick_q && done[G_ANY];
      case (i_req_cmd)
         CMD_PRE:  o_req_ready = o_req_ready && cke_q && done[G_WR_PRE] && done[G_RD_PRE];
         CMD_RD:   o_req_ready = o_req_ready && cke_q && done[G_WR_RD] && done[G_SR_RD];
         CMD_WR:   o_req_ready = o_req_ready && cke_q && done[G_ST_WR] && done[G_RD_WR];
         CMD_EXIT: o_req_ready = o_req_ready && !cke_q;
         default:  o_req_ready = o_req_ready && cke_q;
      endcase
      fire = i_req_valid && o_req_ready;
      load = '0;
      if (fire) begin
         load[G_ANY] = (i_req_cmd == CMD_MRS)
                       || (i_req_cmd inside {CMD_EXIT, CMD_PD_ENTER, CMD_SR_ENTER});
         case (i_req_cmd)
            CMD_WR: begin
               load[G_WR_PRE] = 1'b1;
               load[G_WR_RD]  = 1'b1;
            end
            CMD_RD: begin
               load[G_RD_PRE] = 1'b1;
               load[G_RD_WR]  = 1'b1;
            end
            CMD_BST:  load[G_ST_WR] = 1'b1;
            CMD_EXIT: load[G_SR_RD] = sr_q;
            default: ;
         endcase
      end
   end

   // command pins, power and mode shadow
   always_comb begin
      tick_d = !tick_q;
      cke_d  = cke_q;
      sr_d   = sr_q;
      cl25_d = cl25_q;
      bl_d   = bl_q;
      pins_d = pins_q;
      ba_d   = ba_q;
      addr_d = addr_q;
      if (tick_q) begin
         pins_d = 4'hF;                       // deselect between commands
      end else if (fire) begin
         ba_d   = i_req_bank;
         addr_d = i_req_addr;
         case (i_req_cmd)
            CMD_ACT:      pins_d = 4'h3;
            CMD_RD:       pins_d = 4'h5;
            CMD_WR:       pins_d = 4'h4;
            CMD_PRE:      pins_d = 4'h2;
            CMD_REF:      pins_d = 4'h1;
            CMD_BST:      pins_d = 4'h6;
            CMD_MRS:      pins_d = 4'h0;
            CMD_SR_ENTER: pins_d = 4'h1;
            default:      pins_d = 4'h7;
         endcase
         // clock enable changes only here, so it stands a whole tCK
         if (i_req_cmd == CMD_PD_ENTER || i_req_cmd == CMD_SR_ENTER) begin
            cke_d = 1'b0;
            sr_d  = (i_req_cmd == CMD_SR_ENTER);
         end else if (i_req_cmd == CMD_EXIT) begin
            cke_d = 1'b1;
            sr_d  = 1'b0;
         end
         if (i_req_cmd == CMD_MRS) begin
            bl_d   = bl_beats(i_req_addr[MR_BL_LSB +: 3]);
            cl25_d = (i_req_addr[MR_CL_LSB +: 3] == MR_CL25);
         end
      end
   end

   // write burst drive and read capture
   always_comb begin
      wlat_d   = wlat_q;
      wbeats_d = wbeats_q;
      if (wlat_q != 2'h0) begin
         wlat_d = wlat_q - 2'h1;
      end else if (wbeats_q != 4'h0) begin
         wbeats_d = wbeats_q - 4'h1;
      end
      if (fire && i_req_cmd == CMD_WR) begin
         wlat_d   = 2'(WRITE_DATA_LATENCY + 2'h1); // one clock to the command edge
         wbeats_d = bl_q;
      end
      oe_d         = (wlat_d == 2'h0) && (wbeats_d != 4'h0);
      o_wbeat_take = oe_d;
      dq_d         = oe_d ? i_wdata : dq_q;
      dm_d         = oe_d ? i_wmask : dm_q;
      dqs_d        = oe_d ? !dqs_q : 1'b0;
      rv_d         = link.dq_d_oe;
      rd_d         = link.dq_d_oe ? link.dq_d : rd_q;
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_q   <= 1'b0;
         cke_q    <= 1'b1;
         sr_q     <= 1'b0;
         cl25_q   <= 1'b0;
         bl_q     <= BL_RESET;
         pins_q   <= 4'hF;
         ba_q     <= 2'h0;
         addr_q   <= '0;
         wlat_q   <= 2'h0;
         wbeats_q <= 4'h0;
         dq_q     <= '0;
         dm_q     <= '0;
         oe_q     <= 1'b0;
         dqs_q    <= 1'b0;
         rd_q     <= '0;
         rv_q     <= 1'b0;
      end else begin
         tick_q   <= tick_d;
         cke_q    <= cke_d;
         sr_q     <= sr_d;
         cl25_q   <= cl25_d;
         bl_q     <= bl_d;
         pins_q   <= pins_d;
         ba_q     <= ba_d;
         addr_q   <= addr_d;
         wlat_q   <= wlat_d;
         wbeats_q <= wbeats_d;
         dq_q     <= dq_d;
         dm_q     <= dm_d;
         oe_q     <= oe_d;
         dqs_q    <= dqs_d;
         rd_q     <= rd_d;
         rv_q     <= rv_d;
      end
   end

   // link pins
   assign link.cmd_tick = tick_q;
   assign link.cke      = cke_q;
   assign link.cs_n     = pins_q[3];
   assign link.ras_n    = pins_q[2];
   assign link.cas_n    = pins_q[1];
   assign link.we_n     = pins_q[0];
   assign link.ba       = ba_q;
   assign link.addr     = addr_q;
   assign link.dq_h     = dq_q;
   assign link.dq_h_oe  = oe_q;
   assign link.dm       = dm_q;
   assign link.dqs_h    = dqs_q;
   assign link.dqs_h_oe = oe_q;
   assign o_rdata       = rd_q;
   assign o_rvalid      = rv_q;
endmodule

// *** bench/ddr_link_asserts.sv ***
// link checker: command gaps and data drive
// assumes the bench wires in the link signals
`timescale 1ns/1ps
module ddr_link_asserts
   import ddr_cmd_pkg::*;
(
   input wire logic i_ref_clk, i_resetn, cmd_tick, cke, cs_n, ras_n, cas_n, we_n,
   input wire logic [ROW_W-1:0] addr,
   input wire logic dq_h_oe, dqs_h, dqs_h_oe, dq_d_oe
);
   // command taken by the module end
   wire go = cmd_tick & ~cs_n & cke;
   wire [2:0] c = {ras_n, cas_n, we_n};
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   property p_wr; go && c == 3'h4 |-> ##2 dq_h_oe; endproperty
   a_wr: assert property (p_wr) else $error("write beat late");
   property p_rd; go && c == 3'h5 |-> ##6 dq_d_oe; endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_stop; go && c == 3'h6 |-> ##6 !dq_d_oe; endproperty
   a_stop: assert property (p_stop) else $error("no float after stop");
   property p_pre; go && c == 3'h2 && addr[AP_BIT] |-> ##6 !dq_d_oe; endproperty
   a_pre: assert property (p_pre) else $error("no float after precharge");
   property p_mrs; go && c == 3'h0 |-> ##1 cs_n [*3]; endproperty
   a_mrs: assert property (p_mrs) else $error("mode set gap short");
   property p_cke; $changed(cke) |=> $stable(cke) [*2]; endproperty
   a_cke: assert property (p_cke) else $error("clock enable too short");
   property p_cs; !cs_n |-> cmd_tick; endproperty
   a_cs: assert property (p_cs) else $error("select off tick");
   property p_tog; dqs_h_oe && $past(dqs_h_oe) |-> dqs_h != $past(dqs_h); endproperty
   a_tog: assert property (p_tog) else $error("strobe stuck");
   c_wr: cover property (go && c == 3'h4);
   c_rd: cover property (go && c == 3'h5);
   c_stop: cover property (go && c == 3'h6);
endmodule

// *** bench/ddr_module_command_timing_test.sv ***
// bench: controller end drives the module end over the link
// assumes design and checker files compiled first
`timescale 1ns/1ps
module ddr_module_command_timing_test;
   import ddr_cmd_pkg::*;
   logic clk = 1'h0, rn = 1'h0, vld = 1'h0, rdy, tk, rv, cl;
   cmd_t cmd = CMD_NOP;
   logic [1:0] bk = 2'h0, pw;
   logic [12:0] ad = 13'h0000;
   logic [7:0] bt = 8'h00;
   logic [15:0] rd, q[$];
   logic [3:0] bo, bb;
   int bad_count = 0, check_count = 0, cyc = 0;
   ddr_link_if l();
   ddr_ctrl_end ddr_ctrl_end_i(.i_ref_clk(clk), .i_resetn(rn), .i_req_valid(vld),
      .i_req_cmd(cmd), .i_req_bank(bk), .i_req_addr(ad), .o_req_ready(rdy),
      .i_wdata({bt, bt}), .i_wmask({1'h0, bt == 8'h05}), .o_wbeat_take(tk),
      .o_rdata(rd), .o_rvalid(rv), .link(l));
   ddr_module_end ddr_module_end_i(.i_ref_clk(clk), .i_resetn(rn), .link(l),
      .o_bank_open(bo), .o_pwr_state(pw), .o_cl25(cl), .o_burst_beats(bb));
   ddr_link_asserts ddr_link_asserts_i(.i_ref_clk(clk), .i_resetn(rn),
      .cmd_tick(l.cmd_tick), .cke(l.cke), .cs_n(l.cs_n), .ras_n(l.ras_n),
      .cas_n(l.cas_n), .we_n(l.we_n), .addr(l.addr), .dq_h_oe(l.dq_h_oe),
      .dqs_h(l.dqs_h), .dqs_h_oe(l.dqs_h_oe), .dq_d_oe(l.dq_d_oe));
   // clock
   always #10 clk = ~clk;
   // write beat count, read capture, timeout
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tk) bt <= bt + 8'h01;
      if (rv) q.push_back(rd);
      if (cyc == 3000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // hold a request until taken at a ready edge
   task automatic req(input cmd_t c, input logic [1:0] b, input logic [12:0] a);
      logic hit;
      hit = 1'h0;
      @(posedge clk);
      vld <= 1'h1;
      cmd <= c;
      bk <= b;
      ad <= a;
      repeat (600) if (!hit) begin
         @(negedge clk);
         hit = (rdy === 1'h1);
         @(posedge clk);
      end
      vld <= 1'h0;
   endtask
   // read bank one, optional stop, compare beats
   task automatic rdq(input logic [12:0] a, input bit s, input int n,
                      input logic [15:0] e[4]);
      q.delete();
      req(CMD_RD, 2'h1, a);
      if (s) req(CMD_BST, 2'h1, 13'h0000);
      w(16);
      chk(16'(q.size()), 16'(n));
      for (int i = 0; i < n; i++) chk(q[i], e[i]);
   endtask
   // reset, then the command sequence
   initial begin
      repeat (5) @(posedge clk);
      rn <= 1'h1;
      req(CMD_MRS, 2'h0, 13'h0002);
      req(CMD_ACT, 2'h1, 13'h0123);
      req(CMD_WR, 2'h1, 13'h0000);
      // let the first burst land; a new write restarts the write engine
      w(8);
      req(CMD_WR, 2'h1, 13'h0000);
      w(2);
      chk(bo, 4'h2);
      rdq(13'h0000, 0, 4, '{16'h0404, 16'h0501, 16'h0606, 16'h0707});
      rdq(13'h0000, 1, 2, '{16'h0404, 16'h0501, 16'h0606, 16'h0707});
      req(CMD_MRS, 2'h0, 13'h0061);
      req(CMD_ACT, 2'h2, 13'h0005);
      rdq(13'h0402, 0, 2, '{16'h0606, 16'h0707, 16'h0000, 16'h0000});
      chk(bo, 4'h4);
      chk({cl, bb}, 5'h12);
      req(CMD_ACT, 2'h1, 13'h0007);
      req(CMD_PRE, 2'h2, 13'h0000);
      w(4);
      chk(bo, 4'h2);
      req(CMD_PRE, 2'h0, 13'h0400);
      w(4);
      chk(bo, 4'h0);
      req(CMD_PD_ENTER, 2'h0, 13'h0000);
      w(4);
      chk(pw, 2'h1);
      req(CMD_EXIT, 2'h0, 13'h0000);
      w(4);
      chk(pw, 2'h0);
      req(CMD_SR_ENTER, 2'h0, 13'h0000);
      w(4);
      chk(pw, 2'h2);
      req(CMD_EXIT, 2'h0, 13'h0000);
      w(4);
      chk(pw, 2'h0);
      finish_test();
   end
endmodule
